/* verilog/ldc_pkg.sv */
// Constants, register map and state codes of the laser drive compensation engine
`default_nettype none
package ldc_pkg;
   // Byte map: calibration bytes (kept across reset) and monitor results
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_MODSET = 8'h01;
   localparam logic [7:0] OFS_POWER_SETPOINT = 8'h02;
   localparam logic [7:0] OFS_SUPPLY_COMP_SCALE = 8'h03;
   localparam logic [7:0] OFS_BIAS_TRACKING_PERCENT = 8'h04;
   localparam logic [7:0] OFS_MOD_LINEAR_SLOPE = 8'h05;
   localparam logic [7:0] OFS_MOD_LINEAR_START_TEMP = 8'h06;
   localparam logic [7:0] OFS_MOD_MAX = 8'h07;
   localparam logic [7:0] OFS_BIAS_MAX = 8'h08;
   localparam logic [7:0] OFS_TRACK_ERROR_FACTOR = 8'h09;
   localparam logic [7:0] OFS_TRACK_ERROR_START_TEMP = 8'h0a;
   localparam logic [7:0] OFS_TEMP_OFFSET_LOW = 8'h0b;
   localparam logic [7:0] OFS_TEMP_OFFSET_HIGH = 8'h0c;
   localparam logic [7:0] OFS_TEMP_SLOPE = 8'h0d;
   localparam logic [7:0] OFS_SUPPLY_OFFSET = 8'h0e;
   localparam logic [7:0] OFS_LUT_FIRST = 8'h10;
   localparam logic [7:0] OFS_LUT_LAST = 8'h33;
   localparam logic [7:0] OFS_TEMP_RAW_HIGH = 8'h6e;
   localparam logic [7:0] OFS_TEMP_RAW_LOW = 8'h6f;
   localparam logic [7:0] OFS_SUPPLY_RESULT_HIGH = 8'h70;
   localparam logic [7:0] OFS_SUPPLY_RESULT_LOW = 8'h71;
   localparam logic [7:0] OFS_CALIBRATED_TEMPERATURE = 8'h77;
   localparam int NV_BYTES = 52;
   // Mode byte fields
   localparam int MODE_SW_DISABLE_BIT = 3;
   localparam int MODE_VCOMP_OFF_BIT = 4;
   localparam int MODE_TRACK_EN_BIT = 6;
   // Arithmetic constants
   localparam logic [15:0] PCT_DIV = 16'h0064;
   localparam logic [15:0] KF_DIV = 16'h0190;
   localparam logic [15:0] TRACK_DIV = 16'h2710;
   localparam logic [15:0] VCOMP_DIV = 16'h53fc;
   localparam logic [15:0] SUPPLY_NOMINAL = 16'h00d7;
   localparam logic [23:0] SUPPLY_NUM_DEFAULT = 24'h00f917;
   localparam logic [7:0] TEMP_HYST = 8'h02;
   localparam logic [7:0] TEMP_MAX_CODE = 8'h8c;
   localparam int LUT_STEP = 4;
   localparam int LUT_ENTRIES = 36;
   // Precharge time, least time so rounded up
   localparam int PRECHARGE_NS = 600;
   localparam int CLK_NS = 100;
   localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_SUP = 4'h1,
      ST_TMP = 4'h2,
      ST_KF = 4'h3,
      ST_LIN = 4'h4,
      ST_TRK = 4'h5,
      ST_MODC = 4'h6,
      ST_BIAC = 4'h7,
      ST_LOAD = 4'h8
   } ldc_state_type;
endpackage : ldc_pkg
`default_nettype wire

/* verilog/ldc_divider.sv */
// Sequential restoring divider shared by all compensation terms
`default_nettype none
module ldc_divider #(
   parameter int NW = 24,
   parameter int DW = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   output logic busy,
   output logic done,
   output logic [NW-1:0] quot
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] cnt;
      logic [DW:0] rem;
      logic [NW-1:0] quot;
      logic [DW-1:0] den;
   } ldc_div_type;

   ldc_div_type r_q;
   ldc_div_type r_d;
   logic [DW:0] shifted;

   if (NW < 2 || NW > 63 || DW < 2 || DW > NW)
   begin : g_bad
      $error("ldc_divider: unsupported widths");
   end

   always_comb
   begin
      r_d = r_q;
      r_d.done = 1'b0;
      shifted = {r_q.rem[DW-1:0], r_q.quot[NW-1]};
      if (!r_q.busy && start)
      begin
         r_d.busy = 1'b1;
         r_d.cnt = 6'(NW);
         r_d.rem = '0;
         r_d.quot = num;
         r_d.den = (den == '0) ? DW'(1) : den;
      end
      else if (r_q.busy)
      begin
         r_d.quot = {r_q.quot[NW-2:0], 1'b0};
         r_d.rem = shifted;
         if (shifted >= {1'b0, r_q.den})
         begin
            r_d.rem = shifted - {1'b0, r_q.den};
            r_d.quot[0] = 1'b1;
         end
         r_d.cnt = r_q.cnt - 6'h01;
         if (r_q.cnt == 6'h01)
         begin
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         r_q <= '0;
      else if (ce)
         r_q <= r_d;
   end

   assign busy = r_q.busy;
   assign done = r_q.done;
   assign quot = r_q.quot;
endmodule : ldc_divider
`default_nettype wire

/* verilog/ldc_compensation.sv */
// Laser bias/modulation compensation engine with calibration byte store
// What this block does
// - Supply compensation corrects modulation PWM, and bias PWM in open loop only
// - Compensation strength scaled by percentage byte
// - Offsets and scales take effect after reset
// - Raw temperature published as high/low bytes
// - Sixteen-bit temperature offset added to result
// - Calibrated temperature reported as degrees plus 40
// - Bias lookup table, 4 degree steps
// - Precharge bias from table on (re)enable
// - Precharge finishes within 600 ns
// - Bias-coupled term added to modulation
// - Linear temperature term added above start
// - 2 degree hysteresis on linear term temperature
// - Set-point scale formed above start temperature
// - New set point from stored set point
// - Signed tracking factor, 2 degree hysteresis
// - Supply measured via reference, then linearised
// - Mode bit 4 clear enables supply compensation
// - Mode bit 6 selects tracking compensation
// - PWM driven with 255 minus value
`default_nettype none
module ldc_compensation #(
   parameter logic [23:0] SUPPLY_NUM = ldc_pkg::SUPPLY_NUM_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] mem_addr,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   input wire logic mon_valid,
   input wire logic [15:0] supply_raw,
   input wire logic [15:0] temp_raw,
   input wire logic [15:0] bias_monitor_value,
   input wire logic open_loop,
   input wire logic [7:0] bias_loop_value,
   input wire logic tx_disable_pin,
   output logic laser_enable,
   output logic precharge_active,
   output logic [7:0] bias_pwm,
   output logic [7:0] mod_pwm,
   output logic [7:0] power_setpoint_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic dis;
      logic en;
      logic pre;
      logic [3:0] pre_cnt;
      logic load;
      logic [7:0] act_scale;
      logic [15:0] act_toffs;
      logic [7:0] act_tslope;
      logic [7:0] act_soffs;
      logic [15:0] sraw;
      logic [15:0] traw;
      logic [15:0] ibias;
      logic [15:0] supply_res;
      logic [7:0] cal;
      logic [7:0] hyst;
      logic [7:0] kterm;
      logic [7:0] linear_mod_term;
      logic [7:0] sp_new;
      logic [7:0] modv;
      ldc_pkg::ldc_state_type state;
      logic issued;
      logic [7:0] bias_q;
      logic [7:0] mod_q;
      logic [7:0] sp_q;
      logic [7:0] rdata;
   } ldc_state_reg_type;

   ldc_state_reg_type r_q;
   ldc_state_reg_type r_d;
   logic [7:0] nv [ldc_pkg::NV_BYTES];
   logic div_start;
   logic [23:0] div_num;
   logic [15:0] div_den;
   logic div_busy;
   logic div_done;
   logic [23:0] div_quot;
   logic [7:0] mode;
   logic [7:0] lut_val;
   logic [7:0] mod_sum;
   logic [7:0] bias_open;
   logic [7:0] scale_mod;
   logic [7:0] scale_bias;
   logic [7:0] trk_abs;
   logic [15:0] temp_cal16;
   logic [7:0] cal_new;

   if (SUPPLY_NUM == 24'h000000)
   begin : g_bad
      $error("ldc_compensation: SUPPLY_NUM must be nonzero");
   end

   function automatic logic [7:0] ldc_sat8(input logic [23:0] v, input logic [7:0] lim);
      ldc_sat8 = (v > {16'h0000, lim}) ? lim : v[7:0];
   endfunction : ldc_sat8

   // Supply correction factor, 21500 meaning unity
   function automatic logic [15:0] ldc_vfac(input logic [7:0] scale, input logic [15:0] s);
      int f;
      f = int'(ldc_pkg::VCOMP_DIV) + int'(scale) * (int'(ldc_pkg::SUPPLY_NOMINAL) - int'(s));
      if (f < 0)
         f = 0;
      if (f > 65535)
         f = 65535;
      ldc_vfac = 16'(f);
   endfunction : ldc_vfac

   function automatic logic [7:0] ldc_excess(input logic [7:0] t, input logic [7:0] start);
      ldc_excess = (t > start) ? t - start : 8'h00;
   endfunction : ldc_excess

   ldc_divider #(
      .NW(24),
      .DW(16)
   ) u_div (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .busy(div_busy),
      .done(div_done),
      .quot(div_quot)
   );

   // Calibration bytes survive reset, so this store has no reset
   always_ff @(posedge ref_clk)
   begin
      if (ce && mem_wr && mem_addr < 8'(ldc_pkg::NV_BYTES))
         nv[mem_addr[5:0]] <= mem_wdata;
   end

   always_comb
   begin
      mode = nv[ldc_pkg::OFS_MODE[5:0]];
      lut_val = nv[6'(ldc_pkg::OFS_LUT_FIRST) + 6'(r_q.cal / 8'(ldc_pkg::LUT_STEP))];
      mod_sum = ldc_sat8(24'(nv[ldc_pkg::OFS_MODSET[5:0]]) + 24'(r_q.kterm) + 24'(r_q.linear_mod_term),
         nv[ldc_pkg::OFS_MOD_MAX[5:0]]);
      bias_open = ldc_sat8(24'(lut_val), nv[ldc_pkg::OFS_BIAS_MAX[5:0]]);
      scale_mod = mode[ldc_pkg::MODE_VCOMP_OFF_BIT] ? 8'h00 : r_q.act_scale;
      scale_bias = open_loop ? scale_mod : 8'h00;
      trk_abs = nv[ldc_pkg::OFS_TRACK_ERROR_FACTOR[5:0]][7] ?
         8'h00 - nv[ldc_pkg::OFS_TRACK_ERROR_FACTOR[5:0]] : nv[ldc_pkg::OFS_TRACK_ERROR_FACTOR[5:0]];
      temp_cal16 = div_quot[15:0] + r_q.act_toffs;
      if (temp_cal16[15])
         cal_new = 8'h00;
      else if (temp_cal16 > {8'h00, ldc_pkg::TEMP_MAX_CODE})
         cal_new = ldc_pkg::TEMP_MAX_CODE;
      else
         cal_new = temp_cal16[7:0];
      div_num = '0;
      div_den = ldc_pkg::PCT_DIV;
      case (r_q.state)
         ldc_pkg::ST_SUP:
         begin
            div_num = SUPPLY_NUM;
            div_den = r_q.sraw;
         end
         ldc_pkg::ST_TMP:
            div_num = 24'(r_q.traw) * r_q.act_tslope;
         ldc_pkg::ST_KF:
         begin
            div_num = 24'(r_q.ibias) * nv[ldc_pkg::OFS_BIAS_TRACKING_PERCENT[5:0]];
            div_den = ldc_pkg::KF_DIV;
         end
         ldc_pkg::ST_LIN:
            div_num = 24'(ldc_excess(r_q.hyst, nv[ldc_pkg::OFS_MOD_LINEAR_START_TEMP[5:0]])) *
               nv[ldc_pkg::OFS_MOD_LINEAR_SLOPE[5:0]];
         ldc_pkg::ST_TRK:
         begin
            div_num = 24'(ldc_excess(r_q.hyst, nv[ldc_pkg::OFS_TRACK_ERROR_START_TEMP[5:0]])) * trk_abs *
               nv[ldc_pkg::OFS_POWER_SETPOINT[5:0]];
            div_den = ldc_pkg::TRACK_DIV;
         end
         ldc_pkg::ST_MODC:
         begin
            div_num = 24'(mod_sum) * ldc_vfac(scale_mod, r_q.supply_res);
            div_den = ldc_pkg::VCOMP_DIV;
         end
         ldc_pkg::ST_BIAC:
         begin
            div_num = 24'(bias_open) * ldc_vfac(scale_bias, r_q.supply_res);
            div_den = ldc_pkg::VCOMP_DIV;
         end
         default:
            div_num = '0;
      endcase
   end

   always_comb
   begin
      r_d = r_q;
      div_start = 1'b0;
      // Pin input: three stages, change accepted when last two agree
      r_d.s1 = tx_disable_pin;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      if (r_q.s2 == r_q.s3)
         r_d.dis = r_q.s3;
      r_d.en = !(r_q.dis || mode[ldc_pkg::MODE_SW_DISABLE_BIT]);
      // Shadow copies taken once after reset release
      if (r_q.load)
      begin
         r_d.load = 1'b0;
         r_d.act_scale = nv[ldc_pkg::OFS_SUPPLY_COMP_SCALE[5:0]];
         r_d.act_toffs = {nv[ldc_pkg::OFS_TEMP_OFFSET_HIGH[5:0]], nv[ldc_pkg::OFS_TEMP_OFFSET_LOW[5:0]]};
         r_d.act_tslope = nv[ldc_pkg::OFS_TEMP_SLOPE[5:0]];
         r_d.act_soffs = nv[ldc_pkg::OFS_SUPPLY_OFFSET[5:0]];
      end
      // Precharge on enable edge
      if (r_d.en && !r_q.en)
      begin
         r_d.pre = 1'b1;
         r_d.pre_cnt = 4'(ldc_pkg::PRECHARGE_CYC);
      end
      else if (r_q.pre)
      begin
         r_d.pre_cnt = r_q.pre_cnt - 4'h1;
         if (r_q.pre_cnt == 4'h1)
            r_d.pre = 1'b0;
      end
      if (r_d.pre)
         r_d.bias_q = 8'hff - bias_open;
      else if (!open_loop)
         r_d.bias_q = 8'hff - bias_loop_value;
      // Compensation sequence, one division per state from ST_SUP to ST_BIAC
      if (r_q.state != ldc_pkg::ST_IDLE && r_q.state != ldc_pkg::ST_LOAD && !r_q.issued && !div_busy)
      begin
         div_start = 1'b1;
         r_d.issued = 1'b1;
      end
      case (r_q.state)
         ldc_pkg::ST_IDLE:
            if (mon_valid && !r_q.load)
            begin
               r_d.sraw = supply_raw;
               r_d.traw = temp_raw;
               r_d.ibias = bias_monitor_value;
               r_d.state = ldc_pkg::ST_SUP;
            end
         ldc_pkg::ST_SUP:
            if (div_done)
            begin
               r_d.supply_res = div_quot[15:0] + {8'h00, r_q.act_soffs};
               r_d.issued = 1'b0;
               r_d.state = ldc_pkg::ST_TMP;
            end
         ldc_pkg::ST_TMP:
            if (div_done)
            begin
               r_d.cal = cal_new;
               if ({1'b0, cal_new} >= {1'b0, r_q.hyst} + {1'b0, ldc_pkg::TEMP_HYST} ||
                  {1'b0, r_q.hyst} >= {1'b0, cal_new} + {1'b0, ldc_pkg::TEMP_HYST})
                  r_d.hyst = cal_new;
               r_d.issued = 1'b0;
               r_d.state = ldc_pkg::ST_KF;
            end
         ldc_pkg::ST_KF:
            if (div_done)
            begin
               r_d.kterm = ldc_sat8(div_quot, 8'hff);
               r_d.issued = 1'b0;
               r_d.state = ldc_pkg::ST_LIN;
            end
         ldc_pkg::ST_LIN:
            if (div_done)
            begin
               r_d.linear_mod_term = ldc_sat8(div_quot, 8'hff);
               r_d.issued = 1'b0;
               r_d.state = ldc_pkg::ST_TRK;
            end
         ldc_pkg::ST_TRK:
            if (div_done)
            begin
               if (nv[ldc_pkg::OFS_TRACK_ERROR_FACTOR[5:0]][7])
                  r_d.sp_new = (div_quot > 24'(nv[ldc_pkg::OFS_POWER_SETPOINT[5:0]])) ? 8'h00 :
                     nv[ldc_pkg::OFS_POWER_SETPOINT[5:0]] - div_quot[7:0];
               else
                  r_d.sp_new = ldc_sat8(div_quot + 24'(nv[ldc_pkg::OFS_POWER_SETPOINT[5:0]]), 8'hff);
               r_d.issued = 1'b0;
               r_d.state = ldc_pkg::ST_MODC;
            end
         ldc_pkg::ST_MODC:
            if (div_done)
            begin
               r_d.modv = ldc_sat8(div_quot, nv[ldc_pkg::OFS_MOD_MAX[5:0]]);
               r_d.issued = 1'b0;
               r_d.state = ldc_pkg::ST_BIAC;
            end
         ldc_pkg::ST_BIAC:
            if (div_done)
            begin
               if (open_loop && !r_d.pre)
                  r_d.bias_q = 8'hff - ldc_sat8(div_quot, nv[ldc_pkg::OFS_BIAS_MAX[5:0]]);
               r_d.issued = 1'b0;
               r_d.state = ldc_pkg::ST_LOAD;
            end
         ldc_pkg::ST_LOAD:
         begin
            r_d.mod_q = 8'hff - r_q.modv;
            r_d.sp_q = mode[ldc_pkg::MODE_TRACK_EN_BIT] ? r_q.sp_new :
               nv[ldc_pkg::OFS_POWER_SETPOINT[5:0]];
            r_d.state = ldc_pkg::ST_IDLE;
         end
         default:
            r_d.state = ldc_pkg::ST_IDLE;
      endcase
      // Byte read port
      if (mem_rd)
      begin
         if (mem_addr < 8'(ldc_pkg::NV_BYTES))
            r_d.rdata = nv[mem_addr[5:0]];
         else if (mem_addr == ldc_pkg::OFS_TEMP_RAW_HIGH)
            r_d.rdata = r_q.traw[15:8];
         else if (mem_addr == ldc_pkg::OFS_TEMP_RAW_LOW)
            r_d.rdata = r_q.traw[7:0];
         else if (mem_addr == ldc_pkg::OFS_SUPPLY_RESULT_HIGH)
            r_d.rdata = r_q.supply_res[15:8];
         else if (mem_addr == ldc_pkg::OFS_SUPPLY_RESULT_LOW)
            r_d.rdata = r_q.supply_res[7:0];
         else if (mem_addr == ldc_pkg::OFS_CALIBRATED_TEMPERATURE)
            r_d.rdata = r_q.cal;
         else
            r_d.rdata = 8'h00;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         r_q <= '0;
         r_q.load <= 1'b1;
         r_q.s1 <= 1'b1;
         r_q.s2 <= 1'b1;
         r_q.s3 <= 1'b1;
         r_q.dis <= 1'b1;
         r_q.bias_q <= 8'hff;
         r_q.mod_q <= 8'hff;
      end
      else if (ce)
         r_q <= r_d;
   end

   assign mem_rdata = r_q.rdata;
   assign laser_enable = r_q.en;
   assign precharge_active = r_q.pre;
   assign bias_pwm = r_q.bias_q;
   assign mod_pwm = r_q.mod_q;
   assign power_setpoint_out = r_q.sp_q;
endmodule : ldc_compensation
`default_nettype wire

/* verif/ldc_compensation_chk.sv */
// Port-level assertions of the laser drive compensation engine
`default_nettype none
module ldc_compensation_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] mem_addr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_rdata,
   input wire logic mon_valid,
   input wire logic open_loop,
   input wire logic [7:0] bias_loop_value,
   input wire logic tx_disable_pin,
   input wire logic laser_enable,
   input wire logic precharge_active,
   input wire logic [7:0] bias_pwm,
   input wire logic [7:0] mod_pwm,
   input wire logic [7:0] power_setpoint_out
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // Cycles since the last monitor sample, saturating
   logic [8:0] since_q;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         since_q <= 9'h1ff;
      else if (mon_valid)
         since_q <= 9'h000;
      else if (since_q != 9'h1ff)
         since_q <= since_q + 9'h001;
   end
   property p_pre_len;
      $rose(precharge_active) |-> precharge_active [*6] ##1 !precharge_active;
   endproperty
   a_pre_len: assert property (p_pre_len) else $error("precharge length wrong");
   property p_pre_start;
      $rose(laser_enable) |-> ##[0:1] precharge_active;
   endproperty
   a_pre_start: assert property (p_pre_start) else $error("no precharge on enable");
   property p_pre_hold;
      precharge_active [*3] |-> $stable(bias_pwm);
   endproperty
   a_pre_hold: assert property (p_pre_hold) else $error("bias moved in precharge");
   property p_en_pin;
      tx_disable_pin [*5] |=> !laser_enable;
   endproperty
   a_en_pin: assert property (p_en_pin) else $error("laser not disabled by pin");
   property p_rd_hold;
      !mem_rd |=> $stable(mem_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
   property p_rd_vacant;
      mem_rd && mem_addr >= 8'h34 && mem_addr <= 8'h6d |=> mem_rdata == 8'h00;
   endproperty
   a_rd_vacant: assert property (p_rd_vacant) else $error("vacant byte not zero");
   property p_mod_upd;
      $changed(mod_pwm) |-> since_q >= 9'h032 && since_q <= 9'h12c;
   endproperty
   a_mod_upd: assert property (p_mod_upd) else $error("modulation changed off sequence");
   property p_sp_upd;
      $changed(power_setpoint_out) |-> since_q >= 9'h032 && since_q <= 9'h12c;
   endproperty
   a_sp_upd: assert property (p_sp_upd) else $error("set point changed off sequence");
   property p_closed;
      (!open_loop && laser_enable && !precharge_active) [*2] |-> bias_pwm == 8'hff - $past(bias_loop_value);
   endproperty
   a_closed: assert property (p_closed) else $error("closed loop bias not inverted");
endmodule : ldc_compensation_chk
bind ldc_compensation ldc_compensation_chk i_ldc_compensation_chk (.ref_clk(ref_clk), .rst(rst),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mon_valid(mon_valid),
   .open_loop(open_loop), .bias_loop_value(bias_loop_value), .tx_disable_pin(tx_disable_pin),
   .laser_enable(laser_enable), .precharge_active(precharge_active), .bias_pwm(bias_pwm),
   .mod_pwm(mod_pwm), .power_setpoint_out(power_setpoint_out));
`default_nettype wire

/* verif/ldc_mon_model.sv */
// Monitor front-end model: one converter sample per request
`default_nettype none
module ldc_mon_model (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [15:0] s_in,
   input wire logic [15:0] t_in,
   input wire logic [15:0] b_in,
   output logic mon_valid,
   output logic [15:0] supply_raw,
   output logic [15:0] temp_raw,
   output logic [15:0] bias_monitor_value,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt_q = 0;
   initial
   begin
      mon_valid = 1'b0;
      busy = 1'b0;
      {supply_raw, temp_raw, bias_monitor_value} = 48'h0;
   end
   // Buses are only valid with the strobe; inverted once released
   always @(negedge ref_clk)
   begin
      if (go && !busy)
      begin
         mon_valid <= 1'b1;
         {supply_raw, temp_raw, bias_monitor_value} <= {s_in, t_in, b_in};
         busy <= 1'b1;
         cnt_q <= 0;
      end
      else
      begin
         mon_valid <= 1'b0;
         if (mon_valid)
            {supply_raw, temp_raw, bias_monitor_value} <= ~{supply_raw, temp_raw, bias_monitor_value};
         cnt_q <= cnt_q + 1;
         // Next sample only after the sequence has loaded its outputs
         if (cnt_q == 250)
            busy <= 1'b0;
      end
   end
endmodule : ldc_mon_model
`default_nettype wire

/* verif/test_laser_drive_compensation.sv */
// Self-checking testbench of the laser drive compensation engine
`default_nettype none
`define CHK(got, exp, what) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp); end end
module test_laser_drive_compensation;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] mem_addr = 8'h00;
   logic mem_wr = 1'b0;
   logic mem_rd = 1'b0;
   logic [7:0] mem_wdata = 8'h00;
   logic [7:0] mem_rdata;
   logic mon_valid;
   logic [15:0] supply_raw, temp_raw, bias_monitor_value;
   logic open_loop = 1'b1;
   logic [7:0] bias_loop_value = 8'h00;
   logic tx_disable_pin = 1'b1;
   logic laser_enable, precharge_active, go = 1'b0, busy;
   logic [7:0] bias_pwm, mod_pwm, power_setpoint_out;
   logic [15:0] s_in = 16'h0128, t_in = 16'h0041, b_in = 16'h0028;
   logic [7:0] cfg [0:14] = '{8'h00, 8'h40, 8'h64, 8'h64, 8'h64, 8'h32, 8'h3d, 8'hff, 8'hff, 8'h0a, 8'h37,
      8'h00, 8'h00, 8'h64, 8'h00};
   int miscompares = 0;
   int checked = 0;
   int n;
   always #50 ref_clk = ~ref_clk;
   ldc_compensation i_ldc_compensation (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .mem_addr(mem_addr),
      .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mon_valid(mon_valid),
      .supply_raw(supply_raw), .temp_raw(temp_raw), .bias_monitor_value(bias_monitor_value),
      .open_loop(open_loop), .bias_loop_value(bias_loop_value), .tx_disable_pin(tx_disable_pin),
      .laser_enable(laser_enable), .precharge_active(precharge_active), .bias_pwm(bias_pwm),
      .mod_pwm(mod_pwm), .power_setpoint_out(power_setpoint_out));
   ldc_mon_model i_ldc_mon_model (.ref_clk(ref_clk), .go(go), .s_in(s_in), .t_in(t_in), .b_in(b_in),
      .mon_valid(mon_valid), .supply_raw(supply_raw), .temp_raw(temp_raw),
      .bias_monitor_value(bias_monitor_value), .busy(busy));
   task automatic summarize;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      mem_addr = a;
      mem_wdata = d;
      mem_wr = 1'b1;
      @(negedge ref_clk);
      mem_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      mem_addr = a;
      mem_rd = 1'b1;
      @(negedge ref_clk);
      mem_rd = 1'b0;
      `CHK(mem_rdata, e, "read byte")
   endtask : rd
   task automatic sample(input logic [15:0] s, input logic [15:0] t, input logic [15:0] b);
      @(negedge ref_clk);
      {s_in, t_in, b_in} = {s, t, b};
      go <= 1'b1;
      @(negedge ref_clk);
      go <= 1'b0;
      for (n = 0; n < 400 && (n == 0 || busy); n++)
         @(negedge ref_clk);
      if (n == 400)
      begin
         miscompares++;
         $display("mismatch at %0t: sample never completed", $time);
         summarize();
      end
   endtask : sample
   task automatic outs(input logic [7:0] b, input logic [7:0] m, input logic [7:0] s);
      `CHK(bias_pwm, b, "bias pwm")
      `CHK(mod_pwm, m, "mod pwm")
      `CHK(power_setpoint_out, s, "set point")
   endtask : outs
   task automatic wait_pre;
      for (n = 0; n < 20 && !precharge_active; n++)
         @(negedge ref_clk);
      if (n == 20)
      begin
         `CHK(precharge_active, 1'b1, "precharge start")
         summarize();
      end
   endtask : wait_pre
   task automatic t_reset;
      @(negedge ref_clk);
      rst = 1'b1;
      repeat (4) @(negedge ref_clk);
      outs(8'hff, 8'hff, 8'h00);
      `CHK(mem_rdata, 8'h00, "reset read data")
      rst = 1'b0;
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs;
      for (int i = 0; i < 52; i++)
         wr(i[7:0], i < 15 ? cfg[i] : (i < 16 ? 8'h00 : i[7:0] + 8'h10));
      tx_disable_pin = 1'b0;
      t_reset();
      $display("test registers done");
   endtask : t_regs
   task automatic t_power_on;
      wait_pre();
      `CHK(bias_pwm, 8'hdf, "power-on precharge bias")
      for (n = 0; n < 20 && precharge_active; n++)
         @(negedge ref_clk);
      `CHK(n, 6, "precharge cycles")
      rd(8'h01, 8'h40);
      rd(8'h33, 8'h43);
      wr(8'h34, 8'h5a);
      rd(8'h34, 8'h00);
      rd(8'h50, 8'h00);
      $display("test power-on done");
   endtask : t_power_on
   task automatic t_monitor;
      sample(16'h0128, 16'h0041, 16'h0028);
      rd(8'h6e, 8'h00);
      rd(8'h6f, 8'h41);
      rd(8'h70, 8'h00);
      rd(8'h71, 8'hd7);
      rd(8'h77, 8'h41);
      outs(8'hcf, 8'hb3, 8'h64);
      wr(8'h0d, 8'hc8);
      sample(16'h0128, 16'h0041, 16'h0028);
      rd(8'h77, 8'h41);
      wr(8'h0d, 8'h64);
      $display("test monitor done");
   endtask : t_monitor
   task automatic t_hyst;
      logic [15:0] tt [0:3] = '{16'h0042, 16'h0043, 16'h0042, 16'h0041};
      logic [7:0] me [0:3] = '{8'hb3, 8'hb2, 8'hb2, 8'hb3};
      for (int i = 0; i < 4; i++)
      begin
         sample(16'h0128, tt[i], 16'h0028);
         `CHK(mod_pwm, me[i], "linear term with hysteresis")
      end
      $display("test hysteresis done");
   endtask : t_hyst
   task automatic t_track;
      logic [7:0] md [0:2] = '{8'h40, 8'h40, 8'h00};
      logic [7:0] fc [0:2] = '{8'h0a, 8'hf6, 8'hf6};
      logic [7:0] se [0:2] = '{8'h65, 8'h63, 8'h64};
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h00, md[i]);
         wr(8'h09, fc[i]);
         sample(16'h0128, 16'h0041, 16'h0028);
         `CHK(power_setpoint_out, se[i], "tracked set point")
      end
      $display("test tracking done");
   endtask : t_track
   task automatic t_vcomp;
      sample(16'h0137, 16'h0041, 16'h0028);
      outs(8'hcd, 8'hb0, 8'h64);
      wr(8'h00, 8'h10);
      sample(16'h0137, 16'h0041, 16'h0028);
      outs(8'hcf, 8'hb3, 8'h64);
      wr(8'h00, 8'h00);
      open_loop = 1'b0;
      bias_loop_value = 8'h5a;
      sample(16'h0137, 16'h0041, 16'h0028);
      outs(8'ha5, 8'hb0, 8'h64);
      $display("test supply compensation done");
   endtask : t_vcomp
   task automatic t_reenable;
      tx_disable_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      `CHK(laser_enable, 1'b0, "pin disable")
      tx_disable_pin = 1'b0;
      wait_pre();
      `CHK(bias_pwm, 8'hcf, "re-enable precharge bias")
      repeat (10) @(negedge ref_clk);
      `CHK(bias_pwm, 8'ha5, "closed loop after precharge")
      wr(8'h00, 8'h08);
      repeat (6) @(negedge ref_clk);
      `CHK(laser_enable, 1'b0, "software disable")
      wr(8'h00, 8'h00);
      wait_pre();
      `CHK(precharge_active, 1'b1, "precharge after software enable")
      open_loop = 1'b1;
      $display("test re-enable done");
   endtask : t_reenable
   task automatic t_sat;
      wr(8'h04, 8'hff);
      sample(16'h0128, 16'h0041, 16'hffff);
      outs(8'hcf, 8'h00, 8'h64);
      wr(8'h07, 8'h45);
      wr(8'h08, 8'h28);
      sample(16'h0128, 16'h0041, 16'hffff);
      outs(8'hd7, 8'hba, 8'h64);
      $display("test saturation done");
   endtask : t_sat
   initial
   begin
      t_reset();
      t_regs();
      t_power_on();
      t_monitor();
      t_hyst();
      t_track();
      t_vcomp();
      t_reenable();
      t_sat();
      summarize();
   end
endmodule : test_laser_drive_compensation
`default_nettype wire
